// File: shared/sen_defs.svh
/*
 * register map, reset values, command codes and timing counts of the
 * sensor output formatter.
 * assumes a 125 MHz mclk and a 32-bit axi4-lite register bus.
 */
// Operation
// - disable command floats the output pin
// - enable command restores the driven output
// - format bit one selects pwm carrier
// - format bit zero selects sent frames
// - pwm high time tracks field value
// - optional 50 percent pwm calibration at start
// - sent field is unsigned 0 to 4095
// - nibble is low then high interval
// - select bit picks the fixed interval
// - tick is 4 MHz divided by divider
// - sync, status, data, crc, then pause
// - serial format picks serial channel protocol
// - serial ids cycle zero through seven
// - short format: 8 bits, 16 frames
// - enhanced 16: 12 bits, 18 frames
// - enhanced 24: 16 bits, 18 frames
// - field in first three nibbles, msb first
// - counter nibbles carry frame serial number
// - temperature nibbles in two's complement
// - inverted mode repeats first nibble inverted
// - sync nibble lasts 56 ticks
// - status nibble: status low, serial high
// - pause off varies length, on pads
`ifndef SEN_DEFS_SVH
`define SEN_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SEN_A_CTRL 8'h00
`define SEN_A_TIMING 8'h04
`define SEN_A_PWMPER 8'h08
`define SEN_A_FIELD 8'h0C
`define SEN_A_PAR0 8'h10
`define SEN_A_PAR1 8'h14
`define SEN_A_CMDA 8'h18
`define SEN_A_CMDD 8'h1C
`define SEN_A_STAT 8'h20

// ----------------------------------------
// reset values
// ----------------------------------------
`define SEN_RST_CTRL 32'h0000_0000
`define SEN_RST_TIMING 32'h0000_0503
`define SEN_RST_PWMPER 32'h0000_03E8
`define SEN_RST_ZERO 32'h0000_0000
// part identifier value is arbitrary
`define SEN_PART_ID 16'h0ABC

// ----------------------------------------
// commands and protocol constants
// ----------------------------------------
`define SEN_CMD_ADDR_VOL 6'h24
`define SEN_CMD_DIS 30'h0000_0010
`define SEN_CMD_EN 30'h0000_0000
`define SEN_SYNC_TICKS 16'h0038
`define SEN_NIB_BASE 16'h000C
`define SEN_SHORT_LAST 5'h0F
`define SEN_ENH_LAST 5'h11
`define SEN_CRC4_SEED 4'h5
`define SEN_CRC4_POLY 4'hD
`define SEN_CRC6_SEED 6'h15
`define SEN_CRC6_POLY 6'h19
`define SEN_RESP_OK 2'h0
`define SEN_RESP_ERR 2'h2

// ----------------------------------------
// timing: clock rates in MHz
// ----------------------------------------
`define SEN_CLK_MHZ 125
`define SEN_BASE_MHZ 4

`endif

// File: shared/sen_pkg.sv
/*
 * types and shared checksum step of the sensor output formatter.
 * assumes sen_defs.svh is on the include path.
 */
`include "sen_defs.svh"
package sen_pkg;
	typedef logic [31:0] sen_word_t;
	typedef enum logic [1:0] {SEN_IDLE, SEN_NIB, SEN_PWM} sen_state_e;
	typedef enum logic [1:0] {
		SEN_EX_NONE, SEN_EX_CNT, SEN_EX_TEMP, SEN_EX_INV
	} sen_extra_e;

	// one table-free crc4 step: shift state by a nibble, add the nibble
	function automatic logic [3:0] crc4Step(logic [3:0] c, logic [3:0] n);
		logic [3:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = {r[2:0], 1'b0} ^ (r[3] ? `SEN_CRC4_POLY : 4'h0);
		end
		return r ^ n;
	endfunction : crc4Step
endpackage : sen_pkg

// File: src/sen_tick_gen.sv
/*
 * tick generator: 4 MHz base enable from mclk, divided by the tick divider.
 * assumes mclk at 125 MHz; a divider of zero acts as one.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sen_defs.svh"
module sen_tick_gen (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// control and tick
	input wire logic [7:0] tickDiv,
	output logic tick
);
	import sen_pkg::*;
	localparam logic [6:0] STEP = 7'(`SEN_BASE_MHZ);
	localparam logic [6:0] WRAP = 7'(`SEN_CLK_MHZ - `SEN_BASE_MHZ);
	logic [6:0] acc;
	logic [7:0] div;
	logic baseEn;

	// fractional accumulator: mclk is no whole multiple of 4 MHz
	assign baseEn = acc >= WRAP;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			acc <= 7'h00;
		end else if (baseEn) begin
			acc <= acc - WRAP;
		end else begin
			acc <= acc + STEP;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			div <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (baseEn) begin
				if (div + 8'h01 >= tickDiv) begin
					div <= 8'h00;
					tick <= 1'b1;
				end else begin
					div <= div + 8'h01;
				end
			end
		end
	end
endmodule : sen_tick_gen
`default_nettype wire

// File: src/sen_crc4.sv
/*
 * frame checksum over the status nibble and up to six data nibbles.
 * assumes the first nibble sits in the top bits of nibs.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sen_defs.svh"
module sen_crc4 (
	// nibbles in and count
	input wire logic [27:0] nibs,
	input wire logic [2:0] cnt,
	// checksum out
	output logic [3:0] crc
);
	import sen_pkg::*;

	always_comb begin
		logic [3:0] c;
		c = `SEN_CRC4_SEED;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < cnt) begin
				c = crc4Step(c, nibs[27 - 4 * i -: 4]);
			end
		end
		// trailing zero nibble closes the checksum
		crc = crc4Step(c, 4'h0);
	end
endmodule : sen_crc4
`default_nettype wire

// File: src/sen_output_core.sv
/*
 * sensor output formatter: pwm or tick-timed nibble frames with serial
 * channel, behind an axi4-lite register slave.
 * assumes the field and temperature codes are written by software.
 */
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sen_defs.svh"
module sen_output_core (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire sen_pkg::sen_word_t wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output var sen_pkg::sen_word_t rdata,
	output logic [1:0] rresp,
	// output pin
	output logic outPin,
	output logic outPinOe
);
	import sen_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	sen_word_t ctrl, timing, pwmPer, field, par0, par1, wDataQ;
	logic [5:0] cmdAddr;
	logic [7:0] awAddrQ;
	logic [3:0] wStrbQ;
	logic awFull, wFull, wrFire, cmdFire, outEnabled;
	sen_state_e st;
	logic [3:0] seq, crcSeq, pauseSeq, crcOut, frmNib [0:6];
	logic [2:0] nData, msgId;
	logic [15:0] tickCnt, nibTotal, frameTicks, lowLen, remTicks;
	logic [11:0] frameCnt, sTemp;
	logic [4:0] serFrame, groupLast;
	logic [15:0] msgVal, pwmCnt, pwmHigh;
	logic [27:0] pwmProd;
	logic [14:0] tempX5;
	logic [17:0] enh2, enh3;
	logic [15:0] shortWord;
	logic [5:0] crc6;
	logic [3:0] shortCrc, hiNib;
	logic tick, nibDone, wantPause, frameEnd, startFrame;
	logic serB3, serB2, calibPending;
	logic pwmMode, lovar, pauseMode, calibEn;
	logic [1:0] serFmt, statBits;
	sen_extra_e extra;

	assign pwmMode = ctrl[0];
	assign lovar = ctrl[1];
	assign serFmt = ctrl[3:2];
	assign extra = sen_extra_e'(ctrl[5:4]);
	assign pauseMode = ctrl[6];
	assign calibEn = ctrl[7];
	assign statBits = ctrl[9:8];

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic sen_word_t mergeStrb(sen_word_t old, sen_word_t nw,
			logic [3:0] s);
		sen_word_t r;
		for (int i = 0; i < 4; i++) begin
			r[8 * i +: 8] = s[i] ? nw[8 * i +: 8] : old[8 * i +: 8];
		end
		return r;
	endfunction : mergeStrb

	function automatic logic isMapped(logic [7:0] a);
		case (a)
			`SEN_A_CTRL, `SEN_A_TIMING, `SEN_A_PWMPER, `SEN_A_FIELD,
			`SEN_A_PAR0, `SEN_A_PAR1, `SEN_A_CMDA, `SEN_A_CMDD,
			`SEN_A_STAT: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : isMapped

	function automatic logic [15:0] nibLen(logic [3:0] n);
		return `SEN_NIB_BASE + {12'h000, n};
	endfunction : nibLen

	function automatic logic [3:0] nibAt(logic [3:0] s);
		return (s == crcSeq) ? crcOut : frmNib[3'(s - 4'h1)];
	endfunction : nibAt

	// ----------------------------------------
	// axi4-lite write channels
	// ----------------------------------------
	// a write lands once both halves are held; no response backlog
	assign wrFire = awFull && wFull && !bvalid;
	assign cmdFire = wrFire && (awAddrQ == `SEN_A_CMDD);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			awready <= 1'b1;
			awFull <= 1'b0;
			awAddrQ <= 8'h00;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				awFull <= 1'b1;
				awAddrQ <= awaddr;
			end else if (wrFire) begin
				awFull <= 1'b0;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wready <= 1'b1;
			wFull <= 1'b0;
			wDataQ <= `SEN_RST_ZERO;
			wStrbQ <= 4'h0;
		end else begin
			if (wvalid && wready) begin
				wready <= 1'b0;
				wFull <= 1'b1;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end else if (wrFire) begin
				wFull <= 1'b0;
			end
			if (bvalid && bready) begin
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= `SEN_RESP_OK;
		end else if (wrFire) begin
			bvalid <= 1'b1;
			bresp <= isMapped(awAddrQ) ? `SEN_RESP_OK : `SEN_RESP_ERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ctrl <= `SEN_RST_CTRL;
			timing <= `SEN_RST_TIMING;
			pwmPer <= `SEN_RST_PWMPER;
			field <= `SEN_RST_ZERO;
			par0 <= `SEN_RST_ZERO;
			par1 <= `SEN_RST_ZERO;
			cmdAddr <= 6'h00;
		end else if (wrFire) begin
			case (awAddrQ)
				`SEN_A_CTRL: ctrl <= mergeStrb(ctrl, wDataQ, wStrbQ);
				`SEN_A_TIMING: timing <= mergeStrb(timing, wDataQ, wStrbQ);
				`SEN_A_PWMPER: pwmPer <= mergeStrb(pwmPer, wDataQ, wStrbQ);
				`SEN_A_FIELD: field <= mergeStrb(field, wDataQ, wStrbQ);
				`SEN_A_PAR0: par0 <= mergeStrb(par0, wDataQ, wStrbQ);
				`SEN_A_PAR1: par1 <= mergeStrb(par1, wDataQ, wStrbQ);
				`SEN_A_CMDA: cmdAddr <= wStrbQ[0] ? wDataQ[5:0] : cmdAddr;
				default: ;
			endcase
		end
	end

	// programming commands addressed to the volatile control word
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			outEnabled <= 1'b1;
		end else if (cmdFire && cmdAddr == `SEN_CMD_ADDR_VOL) begin
			if (wDataQ[29:0] == `SEN_CMD_DIS) begin
				outEnabled <= 1'b0;
			end else if (wDataQ[29:0] == `SEN_CMD_EN) begin
				outEnabled <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------
	function automatic sen_word_t readReg(logic [7:0] a);
		case (a)
			`SEN_A_CTRL: return ctrl;
			`SEN_A_TIMING: return timing;
			`SEN_A_PWMPER: return pwmPer;
			`SEN_A_FIELD: return field;
			`SEN_A_PAR0: return par0;
			`SEN_A_PAR1: return par1;
			`SEN_A_CMDA: return {26'h000_0000, cmdAddr};
			`SEN_A_STAT: return {11'h000, serFrame, frameCnt, 2'(st),
				pwmMode, outEnabled};
			default: return `SEN_RST_ZERO;
		endcase
	endfunction : readReg

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= `SEN_RST_ZERO;
			rresp <= `SEN_RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= readReg(araddr);
			rresp <= isMapped(araddr) ? `SEN_RESP_OK : `SEN_RESP_ERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// serial channel
	// ----------------------------------------
	// serial temperature is rescaled from 0.8 to 0.5 lsb per degree
	assign tempX5 = {{3{field[27]}}, field[27:16]}
		+ {field[27], field[27:16], 2'b00};
	assign sTemp = tempX5[14:3];
	assign groupLast = (serFmt == 2'h1) ? `SEN_SHORT_LAST : `SEN_ENH_LAST;

	always_comb begin
		case (msgId)
			3'h0: msgVal = {{4{sTemp[11]}}, sTemp};
			3'h1: msgVal = {8'h00, par0[31:24]};
			3'h2: msgVal = {8'h00, par0[23:16]};
			3'h3: msgVal = {8'h00, par0[15:8]};
			3'h4: msgVal = {8'h00, par0[7:0]};
			3'h5: msgVal = par1[31:16];
			3'h6: msgVal = par1[15:0];
			3'h7: msgVal = `SEN_PART_ID;
			default: msgVal = 16'h0000;
		endcase
	end

	always_comb begin
		logic [3:0] c;
		logic [19:0] m;
		m = 20'h0_0000;
		c = crc4Step(`SEN_CRC4_SEED, {1'b0, msgId});
		c = crc4Step(c, msgVal[7:4]);
		c = crc4Step(c, msgVal[3:0]);
		shortCrc = crc4Step(c, 4'h0);
		shortWord = {1'b0, msgId, msgVal[7:0], shortCrc};
		hiNib = (serFmt == 2'h3) ? msgVal[15:12] : 4'h0;
		m = {hiNib, 1'b0, msgId, msgVal[11:0]};
		crc6 = `SEN_CRC6_SEED;
		for (int i = 19; i >= 0; i--) begin
			crc6 = {crc6[4:0], 1'b0}
				^ ((crc6[5] ^ m[i]) ? `SEN_CRC6_POLY : 6'h00);
		end
		enh2 = {crc6, msgVal[11:0]};
		enh3 = {6'h3F, 1'b0, serFmt[0], hiNib, 1'b0, 1'b0, msgId, 1'b0};
	end

	always_comb begin
		case (serFmt)
			2'h1: begin
				serB3 = (serFrame == 5'h00);
				serB2 = shortWord[4'(5'h0F - serFrame)];
			end
			2'h2, 2'h3: begin
				serB3 = enh3[5'h11 - serFrame];
				serB2 = enh2[5'h11 - serFrame];
			end
			default: begin
				serB3 = 1'b0;
				serB2 = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			serFrame <= 5'h00;
			msgId <= 3'h0;
		end else if (startFrame) begin
			if (serFmt == 2'h0) begin
				serFrame <= 5'h00;
				msgId <= 3'h0;
			end else if (serFrame >= groupLast) begin
				serFrame <= 5'h00;
				msgId <= msgId + 3'h1;
			end else begin
				serFrame <= serFrame + 5'h01;
			end
		end
	end

	// ----------------------------------------
	// frame engine
	// ----------------------------------------
	sen_tick_gen u_tick (
		.mclk(mclk),
		.nrst(nrst),
		.tickDiv(timing[7:0]),
		.tick(tick)
	);

	sen_crc4 u_crc (
		.nibs({frmNib[0], frmNib[1], frmNib[2], frmNib[3], frmNib[4],
			frmNib[5], frmNib[6]}),
		.cnt(nData + 3'h1),
		.crc(crcOut)
	);

	assign crcSeq = {1'b0, nData} + 4'h2;
	assign pauseSeq = crcSeq + 4'h1;
	assign remTicks = timing[31:16] - frameTicks - 16'h0001;
	assign wantPause = pauseMode
		&& (timing[31:16] > frameTicks + `SEN_NIB_BASE);
	assign nibDone = (st == SEN_NIB) && tick
		&& (tickCnt + 16'h0001 == nibTotal);
	assign frameEnd = nibDone
		&& (seq == pauseSeq || (seq == crcSeq && !wantPause));
	assign startFrame = !pwmMode && (st == SEN_IDLE || frameEnd);
	// the fixed interval sets the edge; the other absorbs the value
	assign lowLen = lovar ? nibTotal - {8'h00, timing[15:8]}
		: {8'h00, timing[15:8]};

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st <= SEN_IDLE;
			seq <= 4'h0;
			tickCnt <= 16'h0000;
			nibTotal <= 16'h0000;
			frameTicks <= 16'h0000;
			nData <= 3'h3;
			frameCnt <= 12'h000;
			for (int i = 0; i < 7; i++) begin
				frmNib[i] <= 4'h0;
			end
		end else begin
			case (st)
				SEN_IDLE: if (pwmMode) st <= SEN_PWM;
				SEN_PWM: if (!pwmMode) st <= SEN_IDLE;
				SEN_NIB: if (tick) begin
					tickCnt <= tickCnt + 16'h0001;
					frameTicks <= frameTicks + 16'h0001;
					if (nibDone) begin
						tickCnt <= 16'h0000;
						if (frameEnd) begin
							st <= SEN_IDLE;
						end else if (seq == crcSeq) begin
							seq <= pauseSeq;
							nibTotal <= remTicks;
						end else begin
							seq <= seq + 4'h1;
							nibTotal <= nibLen(nibAt(seq + 4'h1));
						end
					end
				end
				default: st <= SEN_IDLE;
			endcase
			// a new frame overrides the return to idle above
			if (startFrame) begin
				st <= SEN_NIB;
				seq <= 4'h0;
				tickCnt <= 16'h0000;
				nibTotal <= `SEN_SYNC_TICKS;
				frameTicks <= 16'h0000;
				frameCnt <= frameCnt + 12'h001;
				frmNib[0] <= {serB3, serB2, statBits};
				frmNib[1] <= field[11:8];
				frmNib[2] <= field[7:4];
				frmNib[3] <= field[3:0];
				case (extra)
					SEN_EX_CNT: begin
						{frmNib[4], frmNib[5], frmNib[6]} <= frameCnt;
						nData <= 3'h6;
					end
					SEN_EX_TEMP: begin
						{frmNib[4], frmNib[5], frmNib[6]} <= field[27:16];
						nData <= 3'h6;
					end
					SEN_EX_INV: begin
						frmNib[4] <= ~field[11:8];
						nData <= 3'h4;
					end
					default: nData <= 3'h3;
				endcase
			end
		end
	end

	// ----------------------------------------
	// pwm carrier
	// ----------------------------------------
	assign pwmProd = pwmPer[15:0] * field[11:0];
	assign pwmHigh = (calibEn && calibPending) ? {1'b0, pwmPer[15:1]}
		: pwmProd[27:12];

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pwmCnt <= 16'h0000;
			calibPending <= 1'b1;
		end else if (st == SEN_PWM) begin
			if (pwmCnt + 16'h0001 >= pwmPer[15:0]) begin
				pwmCnt <= 16'h0000;
				calibPending <= 1'b0;
			end else begin
				pwmCnt <= pwmCnt + 16'h0001;
			end
		end else begin
			pwmCnt <= 16'h0000;
		end
	end

	// ----------------------------------------
	// output pin
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			outPin <= 1'b1;
			outPinOe <= 1'b1;
		end else begin
			outPinOe <= outEnabled;
			case (st)
				SEN_PWM: outPin <= pwmCnt < pwmHigh;
				SEN_NIB: outPin <= tickCnt >= lowLen;
				default: outPin <= 1'b1;
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_dis;
		cmdFire && cmdAddr == `SEN_CMD_ADDR_VOL
			&& wDataQ[29:0] == `SEN_CMD_DIS |-> ##2 !outPinOe;
	endproperty
	a_dis: assert property (p_dis) else $error("pin not floated");
	property p_en;
		cmdFire && cmdAddr == `SEN_CMD_ADDR_VOL
			&& wDataQ[29:0] == `SEN_CMD_EN |-> ##2 outPinOe;
	endproperty
	a_en: assert property (p_en) else $error("pin not driven");
	property p_pwm;
		st == SEN_PWM && pwmCnt == 16'h0000 && pwmHigh != 16'h0000
			|=> outPin;
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm not high");
	property p_tick;
		tick |=> !tick ##1 !tick;
	endproperty
	a_tick: assert property (p_tick) else $error("tick too fast");
	property p_sync;
		startFrame |=> seq == 4'h0 && nibTotal == 16'h0038;
	endproperty
	a_sync: assert property (p_sync) else $error("bad sync");
	property p_nib;
		st == SEN_NIB && seq != 4'h0 && seq <= crcSeq
			|-> nibTotal == nibLen(nibAt(seq));
	endproperty
	a_nib: assert property (p_nib) else $error("bad nibble");
	property p_low;
		st == SEN_NIB && !lovar && tickCnt < {8'h00, timing[15:8]}
			|=> !outPin;
	endproperty
	a_low: assert property (p_low) else $error("low not fixed");
	property p_inv;
		startFrame && extra == SEN_EX_INV
			|=> frmNib[4] == ~frmNib[1] && nData == 3'h4;
	endproperty
	a_inv: assert property (p_inv) else $error("bad inverse");
	property p_stat;
		startFrame |=> frmNib[0][1:0] == $past(statBits);
	endproperty
	a_stat: assert property (p_stat) else $error("bad status");
endmodule : sen_output_core
`default_nettype wire

// File: bench/sen_sent_rx.sv
/*
 * receiver model: measures each nibble off the output wire, fall to fall.
 * assumes mclk at 125 MHz and the tick divider handed in by the bench.
 */
`timescale 1ns/100ps
`default_nettype none
module sen_sent_rx (
	// clock and divider
	input wire logic mclk,
	input wire logic [7:0] div,
	// pin from the core
	input wire logic outPin,
	input wire logic outPinOe,
	// decoded nibble
	output logic nibStb,
	output int nibTicks,
	output int lowTicks
);
	logic line;
	logic flt = 1'b0;
	logic prev = 1'b1;
	int cyc = 0;
	int lowCyc = 0;
	// a floating pin toggles, so a stale level is never trusted
	assign line = outPinOe ? outPin : flt;
	function automatic int toTicks(int c);
		return (c * 4 + 125 * div / 2) / (125 * div);
	endfunction : toTicks
	always @(posedge mclk) begin
		flt <= ~flt;
		prev <= line;
		nibStb <= 1'b0;
		cyc <= cyc + 1;
		if (!line) lowCyc <= lowCyc + 1;
		if (prev && !line) begin
			nibTicks <= toTicks(cyc);
			lowTicks <= toTicks(lowCyc);
			nibStb <= 1'b1;
			cyc <= 1;
			lowCyc <= 1;
		end
	end
endmodule : sen_sent_rx
`default_nettype wire

// File: bench/sen_output_core_bench.sv
/*
 * bench of the output core: registers, frame decode, commands and pwm.
 * assumes the receiver model beside it and a 125 MHz mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sen_defs.svh"
module sen_output_core_bench;
	import sen_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, div = 8'h01;
	sen_word_t wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, outPin, outPinOe, nibStb;
	logic [1:0] bresp, rresp;
	sen_word_t rdata;
	int nibTicks, lowTicks, err_total = 0, total_checks = 0;

	sen_output_core sen_output_core_inst (.mclk(mclk), .nrst(nrst),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.outPin(outPin), .outPinOe(outPinOe));
	sen_sent_rx sen_sent_rx_inst (.mclk(mclk), .div(div), .outPin(outPin),
		.outPinOe(outPinOe), .nibStb(nibStb), .nibTicks(nibTicks),
		.lowTicks(lowTicks));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict;
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic axWr(input logic [7:0] a, input sen_word_t d,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : axWr
	task automatic axRd(input logic [7:0] a, output sen_word_t d,
		output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : axRd
	task automatic wr(input logic [7:0] a, input sen_word_t d);
		logic [1:0] r;
		axWr(a, d, r);
		chk(r, `SEN_RESP_OK);
	endtask : wr
	task automatic waitSync;
		int k;
		k = 0;
		while (k != 56) begin
			@(posedge mclk);
			if (nibStb) k = nibTicks;
		end
	endtask : waitSync
	function automatic logic [3:0] crcNib(logic [3:0] c, logic [3:0] d);
		for (int b = 0; b < 4; b++) c = {c[2:0], 1'b0} ^ (c[3] ? 4'hD : 4'h0);
		return c ^ d;
	endfunction : crcNib
	task automatic getFrame(input sen_word_t f, input int ex, input logic hi,
		input logic [1:0] st, input logic pz, output logic [11:0] cv);
		logic [3:0] e [8];
		logic [3:0] g [8];
		logic [3:0] c;
		int n, tot;
		n = ex == 0 ? 4 : ex == 3 ? 5 : 7;
		e[0] = {2'b00, st};
		e[1] = f[11:8];
		e[2] = f[7:4];
		e[3] = f[3:0];
		e[4] = ex == 2 ? f[27:24] : ~f[11:8];
		e[5] = f[23:20];
		e[6] = f[19:16];
		waitSync();
		tot = 56;
		for (int i = 0; i <= n; i++) begin
			do @(posedge mclk); while (!nibStb);
			g[i] = nibTicks - 12;
			tot += nibTicks;
			chk(hi ? nibTicks - lowTicks : lowTicks, 5);
		end
		if (ex == 1) for (int i = 4; i < 7; i++) e[i] = g[i];
		cv = {g[4], g[5], g[6]};
		c = 4'h5;
		for (int i = 0; i < n; i++) c = crcNib(c, e[i]);
		e[n] = crcNib(c, 4'h0);
		for (int i = 0; i <= n; i++) chk(g[i], e[i]);
		if (pz) begin
			do @(posedge mclk); while (!nibStb);
			chk(tot + nibTicks, 300);
		end
	endtask : getFrame
	task automatic runCfg(input sen_word_t f, input int ex, input logic hi,
		input logic pz, input int frames);
		logic [1:0] st;
		logic [11:0] cv, pv;
		st = $urandom;
		wr(`SEN_A_FIELD, f);
		wr(`SEN_A_CTRL, {22'h0, st, 1'b0, pz, ex[1:0], 2'b00, hi, 1'b0});
		// the frame under way still carries the old field and nibble format
		waitSync();
		for (int i = 0; i < frames; i++) begin
			pv = cv;
			getFrame(f, ex, hi, st, pz, cv);
			if (i > 0) chk(cv, pv + 12'h001);
		end
	endtask : runCfg
	task automatic cmd(input sen_word_t d, input logic oe);
		wr(`SEN_A_CMDA, {26'h0, `SEN_CMD_ADDR_VOL});
		wr(`SEN_A_CMDD, d);
		repeat (3) @(posedge mclk);
		chk(outPinOe, oe);
	endtask : cmd
	task automatic pwmMeas(output int h, output int p);
		h = 0;
		p = 0;
		while (outPin !== 1'b0) @(posedge mclk);
		while (outPin !== 1'b1) @(posedge mclk);
		while (outPin === 1'b1) begin
			@(posedge mclk);
			h++;
		end
		while (outPin === 1'b0) begin
			@(posedge mclk);
			p++;
		end
	endtask : pwmMeas

	// ----------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------
	initial forever #4 mclk = ~mclk;
	initial begin
		repeat (150000) @(posedge mclk);
		err_total++;
		print_verdict();
	end
	initial begin
		sen_word_t d;
		logic [1:0] r;
		int h, p, f;
		void'($urandom(35));
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		axRd(`SEN_A_CTRL, d, r);
		chk(d, `SEN_RST_CTRL);
		axRd(`SEN_A_TIMING, d, r);
		chk(d, `SEN_RST_TIMING);
		axRd(`SEN_A_PWMPER, d, r);
		chk(d, `SEN_RST_PWMPER);
		axRd(8'h40, d, r);
		chk(r, `SEN_RESP_ERR);
		axWr(8'h44, 32'h0000_0000, r);
		chk(r, `SEN_RESP_ERR);
		wstrb <= 4'h1;
		wr(`SEN_A_PWMPER, 32'hFFFF_FF22);
		wstrb <= 4'hF;
		axRd(`SEN_A_PWMPER, d, r);
		chk(d, 32'h0000_0322);
		wr(`SEN_A_TIMING, 32'h012C_0501);
		runCfg(32'h0000_0FFF, 0, 0, 0, 1);
		runCfg($urandom & 32'h0FFF_0FFF, 1, 1, 0, 2);
		div <= 8'h02;
		wr(`SEN_A_TIMING, 32'h012C_0502);
		runCfg($urandom & 32'h0FFF_0FFF, 2, 0, 0, 1);
		div <= 8'h01;
		wr(`SEN_A_TIMING, 32'h012C_0501);
		runCfg(32'h0000_0000, 3, 0, 1, 1);
		cmd(32'h0000_0010, 1'b0);
		cmd(32'h0000_0011, 1'b0);
		cmd(32'h0000_0000, 1'b1);
		wr(`SEN_A_PWMPER, 32'h0000_0064);
		f = 256 + $urandom % 3584;
		wr(`SEN_A_FIELD, f);
		wr(`SEN_A_CTRL, 32'h0000_0081);
		do axRd(`SEN_A_STAT, d, r); while (d[3:2] !== SEN_PWM);
		p = 0;
		while (outPin !== 1'b0) @(posedge mclk);
		while (outPin === 1'b0) begin
			@(posedge mclk);
			p++;
		end
		chk(p, 50);
		pwmMeas(h, p);
		pwmMeas(h, p);
		chk(h, 100 * f / 4096);
		chk(h + p, 100);
		print_verdict();
	end
endmodule : sen_output_core_bench
`default_nettype wire
